// ---- verilog/overheat_regs.vh ----
// register offsets, field positions, reset values and timing for the overheat pin block
`ifndef OVERHEAT_REGS_VH
`define OVERHEAT_REGS_VH

`define OFS_STATUS2 8'h42
`define OFS_LIMIT_R1 8'h6a
`define OFS_LIMIT_LOC 8'h6b
`define OFS_LIMIT_R2 8'h6c
`define OFS_MASK2 8'h75
`define OFS_CFG3 8'h78
`define OFS_TIMER 8'h79
`define OFS_TIMER_LIMIT 8'h7a
`define OFS_CFG5 8'h7c
`define OFS_CFG4 8'h7d

`define CFG3_ALERT_EN 0
`define CFG3_TIMER_EN 1
`define CFG3_FULL_SPEED_ON_ASSERT 2
`define CFG4_FUNC_LO 0
`define CFG4_FUNC_HI 1
`define CFG4_LATCH_DIS 2
`define CFG4_LATCH_SEL 3
`define CFG5_DRV_R1 5
`define CFG5_DRV_LOC 6
`define CFG5_DRV_R2 7
`define ST2_LATCH 0
`define ST2_OVT 1
`define ST2_TIMER 5

`define FUNC_OVERHEAT 2'h0
`define FUNC_FAN4 2'h1
`define FUNC_GPIO 2'h2
`define FUNC_ALERT 2'h3

`define RST_CFG3 8'h00
`define RST_CFG4 8'h01
`define RST_CFG5 8'h00
`define RST_MASK2 8'h00
`define RST_TIMER_LIMIT 8'h00
`define RST_LIMIT_R1 8'h64
`define RST_LIMIT_LOC 8'h64
`define RST_LIMIT_R2 8'h88

`define CLK_PERIOD_PS 5000
`define TICK_PERIOD_US 22760
// scaled in two steps so the product stays inside 32-bit integer arithmetic
`define TICK_CYCLES ((`TICK_PERIOD_US * 1000) / (`CLK_PERIOD_PS / 1000))

`endif

// ---- verilog/overheat_timer.v ----
// cumulative assertion timer with tick prescaler, saturation and clear on read
`timescale 1ns/1ps
module overheat_timer
#(
  parameter TICK_CYCLES = 4552000
)
(
  input wire clk,
  input wire rst_n,
  input wire run,
  input wire clear,
  output wire [7:0] value
);
  reg [22:0] presc_r;
  reg [7:0] ticks_r;
  reg seen_r;

  // bit 0 reads as one from the first assertion until two ticks are gathered
  assign value = (seen_r && ticks_r == 8'h00) ? 8'h01 : ticks_r; // R13

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      presc_r <= 23'h000000;
      ticks_r <= 8'h00;
      seen_r <= 1'b0;
    end
    else if (clear)
    begin
      // a read during an assertion restarts from zero with bit 0 set again
      presc_r <= 23'h000000; // R14
      ticks_r <= 8'h00; // R12
      seen_r <= run; // R14
    end
    else if (run)
    begin
      seen_r <= 1'b1;
      // prescaler holds while released, so time accumulates across assertions
      if (presc_r == TICK_CYCLES[22:0] - 23'h000001) // R23
      begin
        presc_r <= 23'h000000;
        if (ticks_r != 8'hff) // R12
          ticks_r <= ticks_r + 8'h01; // R11
      end
      else
        presc_r <= presc_r + 23'h000001; // R11
    end
  end
endmodule

// ---- verilog/overheat_pin_ctrl.v ----
// shared overheat pin control: pin function, drive, full_speed_on_assert, latch and assertion timer
`timescale 1ns/1ps
`include "overheat_regs.vh"

// Operation
// R01: alert output off after reset; alert-enable bit makes first candidate pin alert.
// R02: latching variant latches on selected remote over limit, forces fans full.
// R03: bit 2 of configuration four disables latch and forced fans.
// R04: latch holds until temperature below limit and status latch flag cleared.
// R05: latching variant resets limits to 136 for remote two, 100 remote one.
// R06: shared pin field: 01 fan4, 00 overheat, 11 alert, 10 general I/O.
// R07: overheat monitoring also needs timer-enable bit, cleared at reset.
// R08: full_speed_on_assert with pin low forces running fans to full duty.
// R09: full_speed_on_assert only affects fans already running; others stay unchanged.
// R10: full_speed_on_assert cleared leaves fan duty untouched by the pin.
// R11: timer counts only while pin low, pauses, resumes, accumulates.
// R12: timer clears on read and saturates at full scale.
// R13: bit 0 set on first assertion; ticks of 22.76 ms thereafter.
// R14: read during assertion restarts at one; limit zero sets timer flag.
// R15: host clears the timer-limit flag after reading the timer.
// R16: timer above limit sets timer-limit flag and raises alert.
// R17: mask bit 5 suppresses alert from timer-limit flag.
// R18: limit 0 alerts on first assertion, 1 after 45.52 ms.
// R19: configuration five bits 5-7 let channels drive pin low when over.
// R20: external low on the pin is timed when device not driving.
// R21: with all drive bits clear the device never drives the pin; code still pulls it low for alert when the pin field is 11.
// R22: status flags sticky; read clears only once the cause has gone; code keeps overtemp flag (bit 1) live, not sticky.
// R23: tick comes from a clock prescaler; pin sampled through synchroniser.
// R24: alert is OR of unmasked set status flags, held low.
module overheat_pin_ctrl
#(
  parameter LATCH_VARIANT = 0,
  parameter TICK_CYCLES = `TICK_CYCLES
)
(
  input wire clk,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_r,
  input wire [9:0] temp_remote1,
  input wire [9:0] temp_local,
  input wire [9:0] temp_remote2,
  input wire [2:0] fan_running,
  input wire fan4_stall,
  input wire overheat_pin_in,
  output reg overheat_pin_out_r,
  output reg overheat_pin_oe_r,
  output reg pin5_out_r,
  output reg pin5_oe_r,
  output reg [2:0] fan_full_r,
  output reg latched_overheat_out_r
);
  reg rst_meta_r;
  reg rst_sync_r;
  reg pin_meta_r;
  reg pin_sync_r;
  reg [7:0] cfg3_r;
  reg [7:0] cfg4_r;
  reg [7:0] cfg5_r;
  reg [7:0] mask2_r;
  reg [7:0] timer_limit_r;
  reg [7:0] limit_r1_r;
  reg [7:0] limit_loc_r;
  reg [7:0] limit_r2_r;
  reg st_latch_r;
  reg st_timer_r;
  reg latch_r;
  reg [7:0] rd_nxt;
  wire rst_n;
  wire [1:0] func;
  wire monitor;
  wire pin_low;
  wire [2:0] over;
  wire [2:0] drive_sel;
  wire sel_over;
  wire sel_clear;
  wire latch_en;
  wire timer_rd;
  wire st2_rd;
  wire [7:0] timer_value;
  wire timer_cause;
  wire overtemp_flag;
  wire [7:0] status2;
  wire alert;

  // ------------------------------------------------------------
  // reset and pin synchronisers
  // ------------------------------------------------------------
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_r <= 1'b1;
      pin_sync_r <= 1'b1;
    end
    else
    begin
      pin_meta_r <= overheat_pin_in; // R23
      pin_sync_r <= pin_meta_r;
    end
  end

  // ------------------------------------------------------------
  // temperature compares and pin function
  // ------------------------------------------------------------
  // temperatures carry two fraction bits: above limit means at least 0.25 over
  assign over[0] = temp_remote1 > {limit_r1_r, 2'b00};
  assign over[1] = temp_local > {limit_loc_r, 2'b00};
  assign over[2] = temp_remote2 > {limit_r2_r, 2'b00};
  assign func = cfg4_r[`CFG4_FUNC_HI:`CFG4_FUNC_LO]; // R06
  assign monitor = (func == `FUNC_OVERHEAT) && cfg3_r[`CFG3_TIMER_EN]; // R07
  // the pin level counts whoever pulls it, device or an external agent
  assign pin_low = monitor && !pin_sync_r; // R20
  assign drive_sel = {cfg5_r[`CFG5_DRV_R2], cfg5_r[`CFG5_DRV_LOC], cfg5_r[`CFG5_DRV_R1]};
  assign overtemp_flag = |(over & drive_sel); // R19
  assign sel_over = cfg4_r[`CFG4_LATCH_SEL] ? over[2] : over[0]; // R02
  assign sel_clear = cfg4_r[`CFG4_LATCH_SEL] ? (temp_remote2 < {limit_r2_r, 2'b00})
                                               : (temp_remote1 < {limit_r1_r, 2'b00});
  assign latch_en = (LATCH_VARIANT != 0) && !cfg4_r[`CFG4_LATCH_DIS]; // R03

  // ------------------------------------------------------------
  // assertion timer
  // ------------------------------------------------------------
  assign timer_rd = reg_rd && (reg_addr == `OFS_TIMER);
  assign st2_rd = reg_rd && (reg_addr == `OFS_STATUS2);

  overheat_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .run(pin_low), // R11
    .clear(timer_rd), // R12
    .value(timer_value)
  );

  // in fan-4 mode the same flag reports a stalled fan instead
  assign timer_cause = (func == `FUNC_FAN4) ? fan4_stall
                                            : (monitor && timer_value > timer_limit_r); // R16 R18
  assign status2 = {2'b00, st_timer_r, 3'b000, overtemp_flag, st_latch_r};
  // overtemp flag is live, not sticky, so it drops with its cause
  assign alert = |(status2 & ~mask2_r); // R17 R24

  // ------------------------------------------------------------
  // registers and status
  // ------------------------------------------------------------
  always @*
  begin
    case (reg_addr)
      `OFS_STATUS2: rd_nxt = status2;
      `OFS_LIMIT_R1: rd_nxt = limit_r1_r;
      `OFS_LIMIT_LOC: rd_nxt = limit_loc_r;
      `OFS_LIMIT_R2: rd_nxt = limit_r2_r;
      `OFS_MASK2: rd_nxt = mask2_r;
      `OFS_CFG3: rd_nxt = cfg3_r;
      `OFS_TIMER: rd_nxt = timer_value;
      `OFS_TIMER_LIMIT: rd_nxt = timer_limit_r;
      `OFS_CFG5: rd_nxt = cfg5_r;
      `OFS_CFG4: rd_nxt = cfg4_r;
      default: rd_nxt = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg3_r <= `RST_CFG3; // R01 R07
      cfg4_r <= `RST_CFG4;
      cfg5_r <= `RST_CFG5;
      mask2_r <= `RST_MASK2;
      timer_limit_r <= `RST_TIMER_LIMIT;
      limit_r1_r <= `RST_LIMIT_R1; // R05
      limit_loc_r <= `RST_LIMIT_LOC;
      limit_r2_r <= `RST_LIMIT_R2; // R05
      reg_rdata_r <= 8'h00;
    end
    else
    begin
      if (reg_rd)
        reg_rdata_r <= rd_nxt;
      if (reg_wr)
      begin
        case (reg_addr)
          `OFS_LIMIT_R1: limit_r1_r <= reg_wdata;
          `OFS_LIMIT_LOC: limit_loc_r <= reg_wdata;
          `OFS_LIMIT_R2: limit_r2_r <= reg_wdata;
          `OFS_MASK2: mask2_r <= reg_wdata;
          `OFS_CFG3: cfg3_r <= reg_wdata;
          `OFS_TIMER_LIMIT: timer_limit_r <= reg_wdata;
          `OFS_CFG5: cfg5_r <= reg_wdata;
          `OFS_CFG4: cfg4_r <= reg_wdata;
          default: cfg3_r <= cfg3_r;
        endcase
      end
    end
  end

  // set wins over a read clear; a read only clears a flag whose cause is gone
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_timer_r <= 1'b0;
      st_latch_r <= 1'b0;
      latch_r <= 1'b0;
    end
    else
    begin
      if (timer_cause)
        st_timer_r <= 1'b1; // R16
      else if (st2_rd)
        st_timer_r <= 1'b0; // R22 R15
      if (latch_en && sel_over)
        st_latch_r <= 1'b1;
      else if (st2_rd)
        st_latch_r <= 1'b0; // R22
      if (!latch_en)
        latch_r <= 1'b0; // R03
      else if (sel_over)
        latch_r <= 1'b1; // R02
      else if (sel_clear && !st_latch_r)
        latch_r <= 1'b0; // R04
    end
  end

  // ------------------------------------------------------------
  // pins and fan forcing
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overheat_pin_out_r <= 1'b0;
      overheat_pin_oe_r <= 1'b0;
      pin5_out_r <= 1'b0;
      pin5_oe_r <= 1'b0;
      fan_full_r <= 3'b000;
      latched_overheat_out_r <= 1'b0;
    end
    else
    begin
      overheat_pin_out_r <= 1'b0;
      pin5_out_r <= 1'b0;
      // shared pin: drive low for alert or a drive-enabled channel over its limit
      overheat_pin_oe_r <= ((func == `FUNC_ALERT) && alert) ||
                           (monitor && overtemp_flag); // R06 R19 R21
      if (LATCH_VARIANT != 0)
        pin5_oe_r <= latch_r; // R01 R02
      else
        pin5_oe_r <= cfg3_r[`CFG3_ALERT_EN] && alert; // R01
      latched_overheat_out_r <= latch_r; // R02
      // stopped fans are left alone by full_speed_on_assert
      fan_full_r <= ({3{cfg3_r[`CFG3_FULL_SPEED_ON_ASSERT] && pin_low}} & fan_running) |
                    {3{latch_r}}; // R08 R09 R10 R02
    end
  end
endmodule

// ---- bench/cpu_hot_model.sv ----
// far-side hot-signal source sharing the open-drain overheat pin
`timescale 1ns/1ps
module cpu_hot_model (
  input wire hot_req,
  input wire dev_oe,
  output wire pin
);
  // pulled up: a released line reads high, never the last driven value
  assign pin = !(hot_req || dev_oe);
endmodule

// ---- bench/overheat_pin_checker.sv ----
// port-level assertions for the overheat pin block
`timescale 1ns/1ps
module overheat_pin_checker (
  input wire clk,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_r,
  input wire [2:0] fan_running,
  input wire overheat_pin_in,
  input wire overheat_pin_out_r,
  input wire overheat_pin_oe_r,
  input wire pin5_out_r,
  input wire pin5_oe_r,
  input wire [2:0] fan_full_r
);
  // ----
  // config mirror
  // ----
  // the pin rules hang on config bits that never reach a port
  logic [7:0] c3, c4, c5;
  wire en = c3[1] && c4[1:0] == 2'h0;
  wire rt = reg_rd && reg_addr == 8'h79;
  wire rel = c4[1:0] == 2'h1 || c4[1:0] == 2'h2;
  wire quiet = c5[7:5] == 3'h0 && c4[1:0] != 2'h3;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      c3 <= 8'h00;
      c4 <= 8'h01;
      c5 <= 8'h00;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 8'h78) c3 <= reg_wdata;
      if (reg_addr == 8'h7d) c4 <= reg_wdata;
      if (reg_addr == 8'h7c) c5 <= reg_wdata;
    end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_open_drain: assert property (!overheat_pin_out_r && !pin5_out_r)
    else $error("open-drain output driven high");
  a_alert_idle: assert property (!c3[0] && !$past(c3[0]) |-> !pin5_oe_r)
    else $error("alert pin pulled while disabled");
  a_pin_released: assert property (rel && $past(rel) |-> !overheat_pin_oe_r)
    else $error("pin pulled in fan or gpio mode");
  a_no_drive: assert property (quiet && $past(quiet) |-> !overheat_pin_oe_r)
    else $error("pin pulled with drive bits clear");
  a_full_speed_on_assert_off: assert property (!c3[2] && !$past(c3[2]) |-> fan_full_r == 3'h0)
    else $error("fans forced with full_speed_on_assert off");
  a_full_speed_on_assert_idle: assert property ((fan_full_r & ~(fan_running | $past(fan_running)
    | $past(fan_running, 2))) == 3'h0) else $error("idle fan forced");
  a_timer_seen: assert property ((en && !overheat_pin_in)[*6] ##0 rt
    |=> reg_rdata_r != 8'h00) else $error("timer empty during assertion");
  a_timer_idle: assert property (overheat_pin_in[*4] ##0 rt ##1
    (overheat_pin_in && !reg_rd) ##1 (overheat_pin_in && rt) |=> reg_rdata_r == 8'h00)
    else $error("timer counted while released");
  a_read_stands: assert property (!reg_rd |=> $stable(reg_rdata_r))
    else $error("read data changed without read");
  c_sat: cover property (rt ##1 reg_rdata_r == 8'hff);
  c_full_speed_on_assert: cover property (fan_full_r == 3'h5);
  c_alert: cover property (overheat_pin_oe_r && c4[1:0] == 2'h3);
endmodule

bind overheat_pin_ctrl overheat_pin_checker u_overheat_pin_checker (
  .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .fan_running(fan_running),
  .overheat_pin_in(overheat_pin_in), .overheat_pin_out_r(overheat_pin_out_r),
  .overheat_pin_oe_r(overheat_pin_oe_r), .pin5_out_r(pin5_out_r),
  .pin5_oe_r(pin5_oe_r), .fan_full_r(fan_full_r));

// ---- bench/overheat_pin_ctrl_bench.sv ----
// self-checking bench for the overheat pin block
`timescale 1ns/1ps
module overheat_pin_ctrl_bench;
  logic clk, resetn, reg_wr, reg_rd, hot, stall;
  logic [7:0] reg_addr, reg_wdata;
  logic [9:0] t_r1, t_loc, t_r2;
  logic [2:0] fan_running;
  wire [7:0] rdata;
  wire pin, po, poe, p5o, p5oe, lat;
  wire [2:0] fan_full;
  int n_fail = 0;
  int compares = 0;
  // short tick keeps saturation within a few thousand cycles
  overheat_pin_ctrl #(.LATCH_VARIANT(0), .TICK_CYCLES(8)) u_overheat_pin_ctrl (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_r(rdata), .temp_remote1(t_r1), .temp_local(t_loc),
    .temp_remote2(t_r2), .fan_running(fan_running), .fan4_stall(stall),
    .overheat_pin_in(pin), .overheat_pin_out_r(po), .overheat_pin_oe_r(poe),
    .pin5_out_r(p5o), .pin5_oe_r(p5oe), .fan_full_r(fan_full),
    .latched_overheat_out_r(lat));
  cpu_hot_model u_cpu_hot_model (.hot_req(hot), .dev_oe(poe), .pin(pin));
  // ----
  // bus and check tasks
  // ----
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task drive(input logic h, input int n);
    @(posedge clk);
    hot <= h;
    cyc(n);
  endtask
  task final_report;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task t_reset;
    rdc(8'h78, 8'h00);
    rdc(8'h7d, 8'h01);
    rdc(8'h7c, 8'h00);
    rdc(8'h75, 8'h00);
    rdc(8'h7a, 8'h00);
    rdc(8'h6a, 8'h64);
    rdc(8'h6c, 8'h88);
    rdc(8'h00, 8'h00);
    chk({7'h0, p5oe}, 8'h00);
  endtask
  task t_timer;
    wr(8'h7d, 8'h00);
    drive(1'b1, 10);
    drive(1'b0, 4);
    rdc(8'h79, 8'h00);
    wr(8'h78, 8'h02);
    wr(8'h7a, 8'h01);
    drive(1'b1, 3);
    drive(1'b0, 4);
    rdc(8'h79, 8'h01);
    rdc(8'h79, 8'h00);
    rdc(8'h42, 8'h00);
    drive(1'b1, 19);
    drive(1'b0, 29);
    drive(1'b1, 23);
    drive(1'b0, 4);
    rdc(8'h79, 8'h05);
    rdc(8'h42, 8'h20);
    rdc(8'h42, 8'h00);
    wr(8'h7a, 8'h00);
    drive(1'b1, 6);
    rdc(8'h79, 8'h01);
    rdc(8'h79, 8'h01);
    rdc(8'h42, 8'h20);
    rdc(8'h42, 8'h20);
    cyc(2100);
    rdc(8'h79, 8'hff);
    drive(1'b0, 4);
    rdc(8'h79, 8'h01);
  endtask
  task t_alert;
    wr(8'h7d, 8'h03);
    cyc(3);
    chk({7'h0, poe}, 8'h01);
    wr(8'h75, 8'h20);
    cyc(3);
    chk({7'h0, poe}, 8'h00);
    wr(8'h75, 8'h00);
    wr(8'h78, 8'h03);
    cyc(3);
    chk({7'h0, p5oe}, 8'h01);
    rdc(8'h42, 8'h20);
    cyc(3);
    chk({6'h0, p5oe, poe}, 8'h00);
  endtask
  task t_full_speed_on_assert;
    wr(8'h7d, 8'h00);
    wr(8'h78, 8'h06);
    fan_running <= 3'h5;
    drive(1'b1, 5);
    chk({5'h0, fan_full}, 8'h05);
    drive(1'b0, 5);
    chk({5'h0, fan_full}, 8'h00);
    wr(8'h78, 8'h02);
    drive(1'b1, 5);
    chk({5'h0, fan_full}, 8'h00);
    drive(1'b0, 3);
  endtask
  task t_drive;
    wr(8'h7c, 8'h20);
    t_r1 <= 10'd401;
    cyc(5);
    chk({7'h0, poe}, 8'h01);
    @(posedge clk);
    t_r1 <= 10'd400;
    cyc(5);
    chk({7'h0, poe}, 8'h00);
    wr(8'h7c, 8'h00);
    t_r1 <= 10'd401;
    cyc(5);
    chk({7'h0, poe}, 8'h00);
    wr(8'h7c, 8'h80);
    t_r2 <= 10'd545;
    cyc(5);
    chk({7'h0, poe}, 8'h01);
    wr(8'h7d, 8'h02);
    cyc(5);
    chk({7'h0, poe}, 8'h00);
    chk({7'h0, lat}, 8'h00);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #100000;
    n_fail++;
    final_report;
  end
  initial
  begin
    {resetn, reg_wr, reg_rd, hot, stall, reg_addr, reg_wdata} = '0;
    {t_r1, t_loc, t_r2, fan_running} = '0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    cyc(3);
    t_reset;
    t_timer;
    t_alert;
    t_full_speed_on_assert;
    t_drive;
    final_report;
  end
endmodule
